// [hdl/cpd_pkg.sv]
// Constants, enumerations and carriers for the core power domain state control
package cpd_pkg;
  // Power channel state encodings [RULE_11]
  localparam logic [5:0] CPD_PS_ON = 6'h08;
  localparam logic [5:0] CPD_PS_RET = 6'h05;
  localparam logic [5:0] CPD_PS_DBG = 6'h0a;
  localparam logic [5:0] CPD_PS_EMU = 6'h01;
  localparam logic [5:0] CPD_PS_OFF = 6'h00;
  localparam logic [5:0] CPD_MODE_RST = 6'h08;
  // Activity bit positions
  localparam int CPD_ACT_W = 9;
  localparam int CPD_ACT_ON = 8;
  localparam int CPD_ACT_RET = 5;
  localparam int CPD_ACT_EMU = 1;
  // Register map
  localparam logic [3:0] CPD_CTRL_ADDR = 4'h0;
  localparam logic [3:0] CPD_STAT_ADDR = 4'h4;
  localparam logic [2:0] CPD_CTRL_RST = 3'h0;
  localparam int CPD_CTRL_PD = 0;
  localparam int CPD_CTRL_SAME = 1;
  localparam int CPD_CTRL_EMU = 2;
  localparam logic [1:0] CPD_RESP_OKAY = 2'h0;
  localparam logic [1:0] CPD_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {CPD_DOM_OFF, CPD_DOM_RET, CPD_DOM_ON} cpd_dom_e;
  typedef enum logic [1:0] {CPD_CH_IDLE, CPD_CH_FLUSH, CPD_CH_ACK, CPD_CH_DENY} cpd_ch_e;
  typedef enum logic [1:0] {CPD_RUN, CPD_WFI, CPD_DEAD} cpd_run_e;

  typedef struct packed {
    logic awvalid;
    logic [3:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [3:0] araddr;
    logic rready;
  } cpd_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cpd_axi_rsp_s;

  typedef struct packed {
    logic preq;
    logic [5:0] pstate;
  } cpd_pch_in_s;

  typedef struct packed {
    logic paccept;
    logic pdeny;
    logic [CPD_ACT_W-1:0] pactive;
  } cpd_pch_out_s;

  typedef struct packed {
    logic [2:0] rq_sync;
    logic [5:0] ps_s1;
    logic [5:0] ps_s2;
    logic [5:0] ps_s3;
    logic preq_f;
    logic [5:0] pstate_f;
    cpd_ch_e ch;
    cpd_run_e run;
    logic [5:0] mode;
    logic coherent;
    logic [2:0] ctrl;
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cpd_state_s;
endpackage : cpd_pkg

// [hdl/cpd_core_power.sv]
// Core power domain state control with power channel and register slave
// Behaviour
// [RULE_01] The domain is always in exactly one of Off, Retention or On.
// [RULE_02] Debug recovery, On and emulated off give On, retention gives Retention, Off gives Off.
// [RULE_03] The controller can request a mode outside the supported set; such requests are denied here.
// [RULE_04] This core keeps its own mode, untouched by any other core.
// [RULE_05] Setting the powerdown request bit tells the controller a powerdown is wanted, acted on after a wait.
// [RULE_06] After a powerdown wait the caches are flushed and coherence left in hardware, driven by the controller.
// [RULE_07] A wait with the powerdown bit set masks every interrupt and wake event.
// [RULE_08] Such a wait never wakes; only reset restarts the core.
// [RULE_09] After reset the core enters coherence by itself.
// [RULE_10] Debug over powerdown needs the debug unit outside the core domain, else it is unavailable.
// [RULE_11] Channel states encode On 001000, retention 000101, debug recovery 001010 and Off 000000.
// [RULE_12] Activity bit 8 asks On, bit 5 retention, bit 1 emulated off; all low means Off.
// [RULE_13] In retention an incoming access stalls and raises the On activity bit until On returns.
// [RULE_14] In emulated off the controller keeps power on and applies warm reset, keeping debug state.
// [RULE_15] An Off request is acknowledged only after flush and coherence exit complete.
`timescale 1ns/1ps
module cpd_core_power
  import cpd_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register bus
  input wire cpd_axi_req_s axi_req,
  output cpd_axi_rsp_s axi_rsp,
  // Power channel from the controller
  input wire cpd_pch_in_s pch_in,
  output cpd_pch_out_s pch_out,
  // Core side
  input wire logic wfi_exec,
  input wire logic wake_event,
  input wire logic access_req,
  output logic access_stall,
  output logic irq_mask,
  output logic core_wake,
  output logic pd_request,
  output cpd_dom_e dom_state,
  output logic dbg_over_pd_avail,
  // Cache and coherence engine
  output logic flush_req,
  input wire logic flush_done,
  output logic coherent
);

  if (ADDR_W != 4) begin : g_chk
    $error("cpd_core_power: ADDR_W must be 4");
  end

  cpd_state_s st;
  cpd_state_s next_st;
  logic legal;
  logic wr_fire;

  function automatic cpd_dom_e dom_of(input logic [5:0] m);
    if (m == CPD_PS_RET) begin
      dom_of = CPD_DOM_RET;
    end else if (m == CPD_PS_OFF) begin
      dom_of = CPD_DOM_OFF;
    end else begin
      dom_of = CPD_DOM_ON;
    end
  endfunction : dom_of

  // Supported modes, retention only while the core waits
  always_comb begin
    legal = 1'b0;
    if (st.pstate_f == CPD_PS_ON || st.pstate_f == CPD_PS_DBG || st.pstate_f == CPD_PS_EMU) begin
      legal = 1'b1;
    end else if (st.pstate_f == CPD_PS_OFF) begin
      legal = 1'b1;
    end else if (st.pstate_f == CPD_PS_RET) begin
      legal = (st.run != CPD_RUN);
    end
  end

  always_comb begin
    next_st = st;
    wr_fire = 1'b0;
    // Three-stage synchronisers, a change counts when stages two and three agree
    next_st.rq_sync = {st.rq_sync[1:0], pch_in.preq};
    next_st.ps_s1 = pch_in.pstate;
    next_st.ps_s2 = st.ps_s1;
    next_st.ps_s3 = st.ps_s2;
    if (st.rq_sync[1] == st.rq_sync[2]) begin
      next_st.preq_f = st.rq_sync[2];
    end
    if (st.ps_s2 == st.ps_s3) begin
      next_st.pstate_f = st.ps_s3;
    end
    // Enter coherence after reset without software
    if (st.mode != CPD_PS_OFF && st.ch != CPD_CH_FLUSH && st.ch != CPD_CH_ACK) begin
      next_st.coherent = 1'b1; // [RULE_09]
    end
    // Core wait handling
    case (st.run)
      CPD_RUN: begin
        if (wfi_exec) begin
          next_st.run = st.ctrl[CPD_CTRL_PD] ? CPD_DEAD : CPD_WFI; // [RULE_05]
        end
      end
      CPD_WFI: begin
        if (wake_event) begin
          next_st.run = CPD_RUN;
        end
      end
      CPD_DEAD: begin
        next_st.run = CPD_DEAD; // [RULE_08]
      end
      default: begin
        next_st.run = CPD_RUN;
      end
    endcase
    // Power channel handshake
    case (st.ch)
      CPD_CH_IDLE: begin
        if (st.preq_f) begin
          if (!legal) begin
            next_st.ch = CPD_CH_DENY; // [RULE_03]
          end else if (st.pstate_f == CPD_PS_OFF && st.coherent) begin
            next_st.ch = CPD_CH_FLUSH; // [RULE_06]
          end else begin
            next_st.mode = st.pstate_f; // [RULE_04]
            next_st.ch = CPD_CH_ACK;
          end
        end
      end
      CPD_CH_FLUSH: begin
        if (flush_done) begin
          next_st.coherent = 1'b0; // [RULE_15]
          next_st.mode = st.pstate_f;
          next_st.ch = CPD_CH_ACK;
        end
      end
      CPD_CH_ACK, CPD_CH_DENY: begin
        if (!st.preq_f) begin
          next_st.ch = CPD_CH_IDLE;
        end
      end
      default: begin
        next_st.ch = CPD_CH_IDLE;
      end
    endcase
    // Register slave, write address and data taken in either order
    if (axi_req.awvalid && !st.aw_got && !st.bvalid) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st.w_got && !st.bvalid) begin
      next_st.w_got = 1'b1;
      next_st.w_data = axi_req.wdata;
      next_st.w_strb = axi_req.wstrb;
    end
    if (next_st.aw_got && next_st.w_got) begin
      wr_fire = 1'b1;
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = CPD_RESP_OKAY;
      if ({next_st.aw_addr[3:2], 2'h0} == CPD_CTRL_ADDR) begin
        if (next_st.w_strb[0]) begin
          next_st.ctrl = next_st.w_data[2:0];
        end
      end else if ({next_st.aw_addr[3:2], 2'h0} == CPD_STAT_ADDR) begin
        next_st.bresp = CPD_RESP_OKAY;
      end else begin
        next_st.bresp = CPD_RESP_SLVERR;
      end
    end
    if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = CPD_RESP_OKAY;
      next_st.rdata = 32'h0;
      if ({axi_req.araddr[3:2], 2'h0} == CPD_CTRL_ADDR) begin
        next_st.rdata = {29'h0, st.ctrl};
      end else if ({axi_req.araddr[3:2], 2'h0} == CPD_STAT_ADDR) begin
        next_st.rdata = {20'h0, dbg_over_pd_avail, st.coherent, st.run, st.mode, dom_state};
      end else begin
        next_st.rresp = CPD_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st <= '0;
      st.ch <= CPD_CH_IDLE;
      st.run <= CPD_RUN;
      st.mode <= CPD_MODE_RST;
      st.ctrl <= CPD_CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign axi_rsp.awready = !st.aw_got && !st.bvalid;
  assign axi_rsp.wready = !st.w_got && !st.bvalid;
  assign axi_rsp.bvalid = st.bvalid;
  assign axi_rsp.bresp = st.bresp;
  assign axi_rsp.arready = !st.rvalid;
  assign axi_rsp.rvalid = st.rvalid;
  assign axi_rsp.rdata = st.rdata;
  assign axi_rsp.rresp = st.rresp;
  assign dom_state = dom_of(st.mode); // [RULE_01] [RULE_02]
  assign pd_request = st.ctrl[CPD_CTRL_PD]; // [RULE_05]
  assign irq_mask = (st.run == CPD_DEAD); // [RULE_07]
  assign core_wake = (st.run == CPD_WFI) && wake_event; // [RULE_07]
  assign access_stall = (st.mode == CPD_PS_RET) && access_req; // [RULE_13]
  assign dbg_over_pd_avail = !st.ctrl[CPD_CTRL_SAME]; // [RULE_10]
  assign flush_req = (st.ch == CPD_CH_FLUSH); // [RULE_06]
  assign coherent = st.coherent;
  assign pch_out.paccept = (st.ch == CPD_CH_ACK);
  assign pch_out.pdeny = (st.ch == CPD_CH_DENY);
  always_comb begin
    pch_out.pactive = '0;
    pch_out.pactive[CPD_ACT_ON] = (st.run == CPD_RUN) || access_stall; // [RULE_12] [RULE_13]
    pch_out.pactive[CPD_ACT_RET] = (st.run == CPD_WFI) && !access_stall; // [RULE_12]
    pch_out.pactive[CPD_ACT_EMU] = (st.run == CPD_DEAD) && st.ctrl[CPD_CTRL_EMU]; // [RULE_12]
  end

  // Checks
  a_dom_legal: assert property (@(posedge ref_clk) disable iff (reset)
    dom_state != cpd_dom_e'(2'h3)) else $error("domain state out of range"); // [RULE_01]
  a_ret_map: assert property (@(posedge ref_clk) disable iff (reset)
    pch_out.paccept && st.mode == CPD_PS_RET |-> dom_state == CPD_DOM_RET)
    else $error("retention not mapped to Ret"); // [RULE_02]
  a_bad_deny: assert property (@(posedge ref_clk) disable iff (reset)
    st.ch == CPD_CH_IDLE && st.preq_f && !legal |=> pch_out.pdeny ##1 !pch_out.paccept)
    else $error("illegal request not denied"); // [RULE_03]
  a_pd_write: assert property (@(posedge ref_clk) disable iff (reset)
    wr_fire && {next_st.aw_addr[3:2], 2'h0} == CPD_CTRL_ADDR && next_st.w_strb[0] && next_st.w_data[0]
    |=> pd_request) else $error("powerdown request not shown"); // [RULE_05]
  a_off_flushed: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(pch_out.paccept) && st.mode == CPD_PS_OFF |-> !coherent && dom_state == CPD_DOM_OFF)
    else $error("Off accepted before flush"); // [RULE_15]
  a_wfi_masked: assert property (@(posedge ref_clk) disable iff (reset)
    st.run == CPD_RUN && wfi_exec && pd_request |=> irq_mask && !core_wake)
    else $error("powerdown wait not masked"); // [RULE_07]
  a_dead_stays: assert property (@(posedge ref_clk) disable iff (reset)
    st.run == CPD_DEAD |=> st.run == CPD_DEAD [*3]) else $error("powerdown wait woke"); // [RULE_08]
  a_coh_reset: assert property (@(posedge ref_clk)
    reset ##1 !reset [*2] |-> coherent) else $error("no coherence after reset"); // [RULE_09]
  a_ret_stall: assert property (@(posedge ref_clk) disable iff (reset)
    st.mode == CPD_PS_RET && access_req |-> access_stall && pch_out.pactive[CPD_ACT_ON])
    else $error("retention access not stalled"); // [RULE_13]
  a_off_bit: assert property (@(posedge ref_clk) disable iff (reset)
    pch_out.pactive[0] == 1'b0) else $error("Off activity bit driven"); // [RULE_12]
  a_dbg_avail: assert property (@(posedge ref_clk) disable iff (reset)
    st.ctrl[CPD_CTRL_SAME] |-> !dbg_over_pd_avail) else $error("debug over powerdown wrongly offered"); // [RULE_10]
  c_off_done: cover property (@(posedge ref_clk) disable iff (reset)
    flush_req ##[1:50] pch_out.paccept);
  c_ret_entry: cover property (@(posedge ref_clk) disable iff (reset)
    pch_out.paccept && dom_state == CPD_DOM_RET);
  c_dead_wfi: cover property (@(posedge ref_clk) disable iff (reset)
    st.run == CPD_DEAD);
  c_deny: cover property (@(posedge ref_clk) disable iff (reset)
    pch_out.pdeny);
  c_emu_act: cover property (@(posedge ref_clk) disable iff (reset)
    pch_out.pactive[CPD_ACT_EMU]);

  // Domain mapping, channel, flush, activity and stall checks
  a_ret_dom: assert property (@(posedge ref_clk) disable iff (reset)
    st.mode == CPD_PS_RET |-> dom_state == CPD_DOM_RET)
    else $error("retention mode not in Ret"); // [RULE_02]
  a_off_dom: assert property (@(posedge ref_clk) disable iff (reset)
    st.mode == CPD_PS_OFF |-> dom_state == CPD_DOM_OFF)
    else $error("Off mode not in Off"); // [RULE_02]
  a_on_dom: assert property (@(posedge ref_clk) disable iff (reset)
    st.mode == CPD_PS_ON || st.mode == CPD_PS_DBG || st.mode == CPD_PS_EMU |-> dom_state == CPD_DOM_ON)
    else $error("on-type mode not in On"); // [RULE_02]
  a_ret_running: assert property (@(posedge ref_clk) disable iff (reset)
    st.ch == CPD_CH_IDLE && st.preq_f && st.pstate_f == CPD_PS_RET && st.run == CPD_RUN |=> pch_out.pdeny)
    else $error("retention granted to running core"); // [RULE_03]
  a_mode_hold: assert property (@(posedge ref_clk) disable iff (reset)
    st.ch == CPD_CH_ACK || st.ch == CPD_CH_DENY |=> $stable(st.mode))
    else $error("mode changed outside a request"); // [RULE_04]
  a_flush_hold: assert property (@(posedge ref_clk) disable iff (reset)
    flush_req && !flush_done |=> flush_req)
    else $error("flush request dropped early"); // [RULE_06]
  a_flush_exit: assert property (@(posedge ref_clk) disable iff (reset)
    flush_req && flush_done |=> pch_out.paccept && !coherent)
    else $error("flush end not accepted"); // [RULE_06]
  a_off_coh: assert property (@(posedge ref_clk) disable iff (reset)
    st.mode == CPD_PS_OFF |-> !coherent)
    else $error("coherent while Off"); // [RULE_06]
  a_flush_noack: assert property (@(posedge ref_clk) disable iff (reset)
    flush_req |-> !pch_out.paccept)
    else $error("accept during flush"); // [RULE_15]
  a_act_excl: assert property (@(posedge ref_clk) disable iff (reset)
    pch_out.pactive[CPD_ACT_RET] |-> !pch_out.pactive[CPD_ACT_ON])
    else $error("retention and On activity together"); // [RULE_12]
  a_no_stall: assert property (@(posedge ref_clk) disable iff (reset)
    !access_req |-> !access_stall)
    else $error("stall without access"); // [RULE_13]

endmodule : cpd_core_power

// [verif/cpd_pwr_ctrl_model.sv]
// Behavioural power controller on the far side of the core power channel
`timescale 1ns/1ps
module cpd_pwr_ctrl_model
  import cpd_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Bench side
  input wire logic go,
  input wire logic [5:0] mode,
  output logic done,
  output logic accepted,
  // Power channel
  input wire cpd_pch_out_s pch_out,
  output cpd_pch_in_s pch_in
);
  initial begin
    pch_in = '0;
    done = 1'b0;
    accepted = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (!go) begin
        done <= 1'b0;
      end else if (!done) begin
        // Mode held stable through the request
        pch_in <= '{preq: 1'b1, pstate: mode};
        do @(posedge ref_clk); while (!(pch_out.paccept || pch_out.pdeny));
        accepted <= pch_out.paccept;
        // Released mode lines show the inverse value
        pch_in <= '{preq: 1'b0, pstate: ~mode};
        do @(posedge ref_clk); while (pch_out.paccept || pch_out.pdeny);
        done <= 1'b1;
      end
    end
  end
endmodule : cpd_pwr_ctrl_model

// [verif/cpd_core_power_bench.sv]
// Self-checking bench for the core power domain state control
`timescale 1ns/1ps
module cpd_core_power_bench
  import cpd_pkg::*;
;
  typedef struct packed {logic [5:0] mode; logic acc; cpd_dom_e dom;} cpd_row_s;
  localparam cpd_row_s ROWS [0:4] = '{'{6'h0a, 1'b1, CPD_DOM_ON}, '{6'h01, 1'b1, CPD_DOM_ON},
    '{6'h3f, 1'b0, CPD_DOM_ON}, '{6'h05, 1'b0, CPD_DOM_ON}, '{6'h08, 1'b1, CPD_DOM_ON}};
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic wfi_exec = 1'b0, wake_event = 1'b0, access_req = 1'b0, flush_done = 1'b0, go = 1'b0;
  logic [5:0] mode = 6'h00;
  logic access_stall, irq_mask, core_wake, pd_request, dbg_over_pd_avail, flush_req, coherent, done, accepted;
  cpd_axi_req_s axi_req = '0;
  cpd_axi_rsp_s axi_rsp;
  cpd_pch_in_s pch_in;
  cpd_pch_out_s pch_out;
  cpd_dom_e dom_state;
  logic [31:0] rd;
  logic [1:0] rsp;
  int n_fail = 0, n_tests = 0, cyc = 0;

  cpd_core_power i_dut (.ref_clk, .reset, .axi_req, .axi_rsp, .pch_in, .pch_out, .wfi_exec, .wake_event,
    .access_req, .access_stall, .irq_mask, .core_wake, .pd_request, .dom_state, .dbg_over_pd_avail,
    .flush_req, .flush_done, .coherent);
  cpd_pwr_ctrl_model i_ctrl (.ref_clk, .go, .mode, .done, .accepted, .pch_out, .pch_in);

  always #2 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic do_reset();
    reset <= 1'b1;
    tick(4);
    reset <= 1'b0;
    tick(2);
  endtask : do_reset

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      aw_d |= axi_rsp.awready;
      w_d |= axi_rsp.wready;
      if (aw_d) axi_req.awvalid <= 1'b0;
      if (w_d) axi_req.wvalid <= 1'b0;
    end while (!(aw_d && w_d));
    while (!axi_rsp.bvalid) @(posedge ref_clk);
    rsp = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do @(posedge ref_clk); while (!axi_rsp.arready);
    axi_req.arvalid <= 1'b0;
    do @(posedge ref_clk); while (!axi_rsp.rvalid);
    rd = axi_rsp.rdata;
    rsp = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask : axi_rd

  task automatic chan_end();
    do @(posedge ref_clk); while (!done);
    go <= 1'b0;
    @(posedge ref_clk);
  endtask : chan_end

  task automatic chan(input logic [5:0] m);
    mode <= m;
    go <= 1'b1;
    chan_end();
  endtask : chan

  task automatic pulse_wfi();
    wfi_exec <= 1'b1;
    @(posedge ref_clk);
    wfi_exec <= 1'b0;
    @(posedge ref_clk);
  endtask : pulse_wfi

  initial begin
    do_reset();
    axi_rd(CPD_STAT_ADDR);
    chk("status", 32'hc22, rd);
    chk("pactive", 9'h100, pch_out.pactive);
    $display("test reset state done");
    foreach (ROWS[i]) begin
      chan(ROWS[i].mode);
      chk("accepted", ROWS[i].acc, accepted);
      chk("dom_state", ROWS[i].dom, dom_state);
    end
    $display("test mode table done");
    pulse_wfi();
    chan(CPD_PS_RET);
    chk("dom_state", CPD_DOM_RET, dom_state);
    access_req <= 1'b1;
    tick(1);
    chk("access_stall", 1'b1, access_stall);
    chk("pactive_on", 1'b1, pch_out.pactive[CPD_ACT_ON]);
    chan(CPD_PS_ON);
    access_req <= 1'b0;
    chk("dom_state", CPD_DOM_ON, dom_state);
    wake_event <= 1'b1;
    #1;
    chk("core_wake", 1'b1, core_wake);
    tick(1);
    wake_event <= 1'b0;
    $display("test retention done");
    axi_wr(4'h8, 32'h1);
    chk("bresp_unmapped", CPD_RESP_SLVERR, rsp);
    chk("pd_request", 1'b0, pd_request);
    axi_rd(4'h8);
    chk("rresp_unmapped", CPD_RESP_SLVERR, rsp);
    axi_wr(CPD_CTRL_ADDR, 32'h2);
    chk("dbg_avail", 1'b0, dbg_over_pd_avail);
    axi_wr(CPD_CTRL_ADDR, 32'h5);
    axi_rd(CPD_CTRL_ADDR);
    chk("ctrl", 32'h5, rd);
    chk("pd_request", 1'b1, pd_request);
    chk("dbg_avail", 1'b1, dbg_over_pd_avail);
    $display("test registers done");
    pulse_wfi();
    wake_event <= 1'b1;
    tick(2);
    chk("irq_mask", 1'b1, irq_mask);
    chk("core_wake", 1'b0, core_wake);
    chk("pactive_emu", 1'b1, pch_out.pactive[CPD_ACT_EMU]);
    mode <= CPD_PS_OFF;
    go <= 1'b1;
    do @(posedge ref_clk); while (!flush_req);
    repeat (6) begin
      @(posedge ref_clk);
      chk("early_accept", 1'b0, pch_out.paccept);
    end
    flush_done <= 1'b1;
    chan_end();
    flush_done <= 1'b0;
    chk("accepted", 1'b1, accepted);
    chk("dom_state", CPD_DOM_OFF, dom_state);
    chk("coherent", 1'b0, coherent);
    tick(20);
    chk("irq_mask", 1'b1, irq_mask);
    axi_rd(CPD_STAT_ADDR);
    chk("run_state", 2'h2, rd[9:8]);
    $display("test powerdown done");
    wake_event <= 1'b0;
    do_reset();
    chk("coherent", 1'b1, coherent);
    chk("dom_state", CPD_DOM_ON, dom_state);
    chk("irq_mask", 1'b0, irq_mask);
    chk("pd_request", 1'b0, pd_request);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : cpd_core_power_bench
